// ### core/adc_link_pkg.sv
// constants shared by both ends of the converter serial link
// assumes a 40 MHz system clock on the host side and the link clock at the device
package adc_link_pkg;
    localparam int RESULT_BITS = 12;
    localparam logic [5:0] EDGE_PD_MIN = 6'h02;
    localparam logic [5:0] EDGE_AWAKE = 6'h0A;
    localparam logic [5:0] EDGE_SINGLE = 6'h0E;
    localparam logic [5:0] EDGE_PADDED = 6'h10;
    localparam logic [5:0] EDGE_DUAL = 6'h20;
    localparam int SYS_CLK_MHZ = 40;
    localparam int POWER_UP_NS = 1000;
    localparam int POWER_UP_CYCLES = (POWER_UP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int QUIET_NS = 50;
    localparam int QUIET_CYCLES = (QUIET_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SCLK_HALF_CYCLES = 2;
    localparam logic [1:0] POWER_RESET = 2'h0;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL = 2'b10
    } power_mode_e;
endpackage

// ### core/adc_link_if.sv
// serial link between host and converter
// result lines carry separate enables; nothing resolves them, the host reads the lines directly
`timescale 1ns/100ps
interface adc_link_if;
    logic chipSelectB;
    logic serialClk;
    logic resultLineA;
    logic resultLineAOe;
    logic resultLineB;
    logic resultLineBOe;
    logic [2:0] channelSelect;
    logic inputConfigSelect;
    logic rangeSelect;

    modport device (
        input chipSelectB,
        input serialClk,
        output resultLineA,
        output resultLineAOe,
        output resultLineB,
        output resultLineBOe,
        input channelSelect,
        input inputConfigSelect,
        input rangeSelect
    );
    modport host (
        output chipSelectB,
        output serialClk,
        input resultLineA,
        input resultLineAOe,
        input resultLineB,
        input resultLineBOe,
        output channelSelect,
        output inputConfigSelect,
        output rangeSelect
    );
endinterface

// ### core/sync_bit.sv
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module sync_bit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic async,
    output logic synced
);
    logic stage1_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1_r <= 1'b0;
            synced <= 1'b0;
        end else begin
            stage1_r <= async;
            synced <= stage1_r;
        end
    end
endmodule

// ### core/adc_frame_device.sv
// converter end: frame counting, power mode and result shifting
// clocked by the link's serial clock; chip select is a frame-bounding async level
// Summary of operation
// - chip select fall samples input, starts conversion
// - host keeps chip select low ten edges
// - rise in edges 10..13 aborts, stays powered
// - fourteen clocks convert and read one result
// - after fourteen, line drives until chip select rises
// - two more clocks shift two zero bits
// - further sixteen clocks shift other result
// - identification bit precedes each result
// - dual frame tri-states at 32nd edge
// - host may idle chip select low after 32
// - host waits quiet interval before next frame
// - partial power-down keeps reference only
// - rise in edges 2..9 enters partial power-down
// - rise before edge two keeps normal mode
// - dummy frame past ten edges powers up
// - early rise during wake returns to partial
// - partial plus window rise enters full power-down
// - full power-down turns everything off
// - host need not finish clocks after power-down request
// - host waits full power-up after dummy frame
// - inputs captured at fall apply next conversion
`timescale 1ns/100ps
module adc_frame_device
    import adc_link_pkg::*;
(
    adc_link_if.device link,
    input wire logic [adc_link_pkg::RESULT_BITS-1:0] sampleA,
    input wire logic [adc_link_pkg::RESULT_BITS-1:0] sampleB,
    output logic [1:0] powerMode,
    output logic referenceOn,
    output logic analogOn,
    output logic [2:0] activeChannel,
    output logic activeConfig,
    output logic activeRange
);
    import adc_link_pkg::*;

    logic [5:0] edgeCount_r;
    logic [RESULT_BITS-1:0] holdA_r;
    logic [RESULT_BITS-1:0] holdB_r;
    logic [2:0] nextChannel_r;
    logic nextConfig_r;
    logic nextRange_r;
    logic frameMode_r;
    logic outA_r;
    logic outB_r;
    logic oe_r;
    power_mode_e mode_r;
    power_mode_e mode_nxt;

    // shift slot k carries: zero, id, 12 data, 2 zeros; then line A repeats with the other result
    function automatic logic slotBit(input logic [5:0] k, input logic id,
                                     input logic [RESULT_BITS-1:0] d);
        logic [5:0] j;
        j = k;
        if (j == 6'h01)
            return id;
        else if (j >= 6'h02 && j < EDGE_SINGLE)
            return d[RESULT_BITS - 1 - (j - 6'h02)];
        else
            return 1'b0;
    endfunction

    // frame start: sample both results and capture inputs; count was cleared at the rise
    always_ff @(negedge link.chipSelectB) begin
        holdA_r <= sampleA;
        holdB_r <= sampleB;
        activeChannel <= nextChannel_r;
        activeConfig <= nextConfig_r;
        activeRange <= nextRange_r;
        nextChannel_r <= link.channelSelect;
        nextConfig_r <= link.inputConfigSelect;
        nextRange_r <= link.rangeSelect;
    end

    // counter runs on link clock while chip select is low; cleared asynchronously by it
    always_ff @(negedge link.serialClk or posedge link.chipSelectB) begin
        if (link.chipSelectB) begin
            edgeCount_r <= 6'h00;
        end else if (edgeCount_r != 6'h3F) begin
            edgeCount_r <= edgeCount_r + 6'h01;
        end
    end

    // output shifter: drive from first falling link clock edge, stop at 32nd edge (line B at 16th) or on rise
    always_ff @(negedge link.serialClk or posedge link.chipSelectB) begin
        if (link.chipSelectB) begin
            oe_r <= 1'b0;
            outA_r <= 1'b0;
            outB_r <= 1'b0;
        end else begin
            if (edgeCount_r + 6'h01 >= EDGE_DUAL)
                oe_r <= 1'b0;
            else
                oe_r <= 1'b1;
            if (edgeCount_r + 6'h01 < EDGE_PADDED) begin
                outA_r <= slotBit(edgeCount_r + 6'h01, 1'b0, holdA_r);
                outB_r <= slotBit(edgeCount_r + 6'h01, 1'b1, holdB_r);
            end else begin
                outA_r <= slotBit(edgeCount_r + 6'h01 - EDGE_PADDED, 1'b1, holdB_r);
                outB_r <= 1'b0;
            end
        end
    end

    // power decision taken at the rise of chip select from the edge count
    always_comb begin
        mode_nxt = mode_r;
        if (edgeCount_r >= EDGE_AWAKE) begin
            mode_nxt = PWR_NORMAL;
        end else if (edgeCount_r >= EDGE_PD_MIN) begin
            if (mode_r == PWR_NORMAL)
                mode_nxt = PWR_PARTIAL;
            else
                mode_nxt = PWR_FULL;
        end else begin
            mode_nxt = mode_r;
        end
    end

    always_ff @(posedge link.chipSelectB) begin
        mode_r <= mode_nxt;
    end

    // analog power: waking starts at frame start, falls back at the rise
    always_comb begin
        case (mode_r)
            PWR_NORMAL: begin
                referenceOn = 1'b1;
                analogOn = 1'b1;
            end
            PWR_PARTIAL: begin
                referenceOn = 1'b1;
                analogOn = !link.chipSelectB;
            end
            PWR_FULL: begin
                referenceOn = !link.chipSelectB;
                analogOn = !link.chipSelectB;
            end
            default: begin
                referenceOn = 1'b0;
                analogOn = 1'b0;
            end
        endcase
    end

    assign powerMode = mode_r;
    assign link.resultLineA = outA_r;
    assign link.resultLineB = outB_r;
    assign link.resultLineAOe = oe_r;
    assign link.resultLineBOe = oe_r && (edgeCount_r < EDGE_PADDED);
endmodule

// ### core/adc_frame_host.sv
// host end: makes chip select and serial clock, reads one or two results
// assumes a 40 MHz clk; link clock derived by divider, result lines synchronised
`timescale 1ns/100ps
module adc_frame_host
    import adc_link_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    adc_link_if.host link,
    input wire logic start,
    input wire logic [5:0] frameEdges,
    input wire logic [2:0] channelSel,
    input wire logic configSel,
    input wire logic rangeSel,
    output logic busy,
    output logic done,
    output logic [31:0] dataA,
    output logic [15:0] dataB
);
    import adc_link_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_QUIET = 2'b10
    } host_state_e;

    host_state_e state_r;
    logic [5:0] edges_r;
    logic [5:0] target_r;
    logic [7:0] timer_r;
    logic sclk_r;
    logic csB_r;
    logic lineA;
    logic lineB;
    logic [2:0] chan_r;
    logic cfg_r;
    logic rng_r;

    sync_bit syncA (.clk(clk), .rst_b(rst_b), .async(link.resultLineA), .synced(lineA));
    sync_bit syncB (.clk(clk), .rst_b(rst_b), .async(link.resultLineB), .synced(lineB));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            csB_r <= 1'b1;
            sclk_r <= 1'b1;
            edges_r <= 6'h00;
            target_r <= 6'h00;
            timer_r <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            chan_r <= 3'h0;
            cfg_r <= 1'b0;
            rng_r <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_RUN;
                        csB_r <= 1'b0;
                        busy <= 1'b1;
                        edges_r <= 6'h00;
                        timer_r <= 8'h00;
                        target_r <= frameEdges;
                        chan_r <= channelSel;
                        cfg_r <= configSel;
                        rng_r <= rangeSel;
                    end
                end
                ST_RUN: begin
                    if (timer_r == 8'(SCLK_HALF_CYCLES - 1)) begin
                        timer_r <= 8'h00;
                        if (edges_r == target_r) begin
                            csB_r <= 1'b1;
                            sclk_r <= 1'b1;
                            state_r <= ST_QUIET;
                        end else begin
                            sclk_r <= !sclk_r;
                            if (sclk_r)
                                edges_r <= edges_r + 6'h01;
                        end
                    end else begin
                        timer_r <= timer_r + 8'h01;
                    end
                end
                ST_QUIET: begin
                    // powerup wait covers quiet too
                    if (timer_r == 8'(POWER_UP_CYCLES + QUIET_CYCLES)) begin
                        state_r <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        timer_r <= timer_r + 8'h01;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // sample just before each falling sclk edge; lags by sync delay, tolerant at this ratio
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dataA <= 32'h0000_0000;
            dataB <= 16'h0000;
        end else if (state_r == ST_RUN && sclk_r && timer_r == 8'(SCLK_HALF_CYCLES - 1)) begin
            dataA <= {dataA[30:0], lineA};
            dataB <= {dataB[14:0], lineB};
        end
    end

    assign link.chipSelectB = csB_r;
    assign link.serialClk = sclk_r;
    assign link.channelSelect = chan_r;
    assign link.inputConfigSelect = cfg_r;
    assign link.rangeSelect = rng_r;
endmodule

// ### testbench/adc_link_sva.sv
// checker on the wires between host and converter ends
// assumes the serial clock idles high and is made by the host from clk
`timescale 1ns/100ps
module adc_link_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic chipSelectB,
    input wire logic serialClk,
    input wire logic resultLineAOe,
    input wire logic resultLineBOe
);
    logic [5:0] fallCnt_r;
    // async clear: the link clock stands still between frames
    always_ff @(negedge serialClk or posedge chipSelectB) begin
        if (chipSelectB) begin
            fallCnt_r <= 6'h00;
        end else if (fallCnt_r != 6'h3F) begin
            fallCnt_r <= fallCnt_r + 6'h01;
        end
    end
    sequence frame_end_s;
        $rose(chipSelectB);
    endsequence
    sequence lines_off_s;
        !resultLineAOe && !resultLineBOe;
    endsequence
    cs_release_a: assert property (@(posedge clk) disable iff (!rst_b)
        frame_end_s |-> ##[0:3] lines_off_s) else $error("result lines still driven after frame end");
    quiet_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
        frame_end_s |-> chipSelectB [*2]) else $error("chip select low again too soon");
    idle_tristate_a: assert property (@(posedge clk) disable iff (!rst_b)
        chipSelectB [*4] |-> lines_off_s) else $error("result line driven outside frame");
    sclk_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        chipSelectB [*4] |-> serialClk) else $error("serial clock not idle between frames");
    pre_drive_a: assert property (@(negedge serialClk) disable iff (chipSelectB)
        fallCnt_r == 6'h00 |-> lines_off_s) else $error("line driven before first fall");
    line_a_drive_a: assert property (@(negedge serialClk) disable iff (chipSelectB)
        fallCnt_r inside {[6'h01:6'h1F]} |-> resultLineAOe) else $error("line A released in frame");
    dual_release_a: assert property (@(negedge serialClk) disable iff (chipSelectB)
        fallCnt_r >= 6'h20 |-> !resultLineAOe) else $error("line A driven past 32nd fall");
    line_b_drive_a: assert property (@(negedge serialClk) disable iff (chipSelectB)
        fallCnt_r inside {[6'h01:6'h0F]} |-> resultLineBOe) else $error("line B released in frame");
endmodule

// ### testbench/adc_frame_power_mode_control_tb_top.sv
// bench joining host and converter ends across the link interface
// assumes the host makes the link clock; device modes settle by done
`timescale 1ns/100ps
module adc_frame_power_mode_control_tb_top;
    import adc_link_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [5:0] frameEdges = 6'h10;
    logic [2:0] channelSel = 3'h0;
    logic configSel = 1'b0;
    logic rangeSel = 1'b0;
    logic [RESULT_BITS-1:0] sampleA = 12'hA5C;
    logic [RESULT_BITS-1:0] sampleB = 12'h3C6;
    logic busy, done, referenceOn, analogOn, activeConfig, activeRange;
    logic [31:0] dataA;
    logic [15:0] dataB;
    logic [1:0] powerMode;
    logic [2:0] activeChannel;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    adc_link_if link();
    adc_frame_host u_adc_frame_host (.clk(clk), .rst_b(rst_b), .link(link), .start(start),
        .frameEdges(frameEdges), .channelSel(channelSel), .configSel(configSel), .rangeSel(rangeSel),
        .busy(busy), .done(done), .dataA(dataA), .dataB(dataB));
    adc_frame_device u_adc_frame_device (.link(link), .sampleA(sampleA), .sampleB(sampleB),
        .powerMode(powerMode), .referenceOn(referenceOn), .analogOn(analogOn),
        .activeChannel(activeChannel), .activeConfig(activeConfig), .activeRange(activeRange));
    adc_link_sva u_adc_link_sva (.clk(clk), .rst_b(rst_b), .chipSelectB(link.chipSelectB),
        .serialClk(link.serialClk), .resultLineAOe(link.resultLineAOe), .resultLineBOe(link.resultLineBOe));
    always #12.5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // 13 frames of at most 200 cycles each
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("MISMATCH at %0t: run hung", $time);
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic frame(input logic [5:0] edges);
        int i;
        @(negedge clk);
        frameEdges = edges;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 600; i++) begin
            if (done === 1'b1) break;
            @(negedge clk);
        end
        check(i < 600, 1'b1, "done within bound");
        check(busy, 1'b0, "busy after done");
    endtask
    // mode walk; first frame leaves the unreset mode defined
    task automatic t_modes();
        logic [5:0] edges [10] = '{6'h10, 6'h05, 6'h01, 6'h09, 6'h0A, 6'h01, 6'h02, 6'h0D, 6'h0E, 6'h0A};
        logic [1:0] modes [10] = '{PWR_NORMAL, PWR_PARTIAL, PWR_PARTIAL, PWR_FULL, PWR_NORMAL,
            PWR_NORMAL, PWR_PARTIAL, PWR_NORMAL, PWR_NORMAL, PWR_NORMAL};
        logic [4:0] sel;
        logic [4:0] prevSel;
        prevSel = 5'h00;
        for (int i = 0; i < 10; i++) begin
            sel = 5'(i * 7 + 3);
            {channelSel, configSel, rangeSel} = sel;
            frame(edges[i]);
            check(powerMode, modes[i], "power mode");
            check(referenceOn, modes[i] != PWR_FULL, "reference");
            check(analogOn, modes[i] == PWR_NORMAL, "analog");
            if (i > 0) check({activeChannel, activeConfig, activeRange}, prevSel, "next-frame setup");
            prevSel = sel;
        end
        $display("t_modes finished");
    endtask
    task automatic t_capture();
        sampleA = 12'hA5C;
        fork
            frame(6'h10);
            begin
                wait (link.chipSelectB === 1'b0);
                @(negedge clk);
                sampleA = 12'h123;
                sampleB = 12'h456;
            end
        join
        check(dataA[15:0], {2'b00, 12'hA5C, 2'b00}, "padded line A");
        check(dataB, {2'b01, 12'h3C6, 2'b00}, "padded line B");
        $display("t_capture finished");
    endtask
    task automatic t_dual();
        frame(6'h20);
        check(dataA, {2'b00, sampleA, 2'b00, 2'b01, sampleB, 2'b00}, "dual line A");
        frame(6'h24);
        check(powerMode, PWR_NORMAL, "idle low past 32");
        $display("t_dual finished");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        t_modes();
        t_capture();
        t_dual();
        tally_and_finish();
    end
endmodule
